// ==== design/flow_cond_consts.vh ====
`ifndef FLOW_COND_CONSTS_VH
`define FLOW_COND_CONSTS_VH

// timing
`define CLK_MHZ           200
`define SAMPLE_MS         20
`define SIM_MIN_MS        60000
// register byte offsets
`define OFS_CTRL          8'h00
`define OFS_FILTER        8'h04
`define OFS_SPAN          8'h08
`define OFS_RSTART        8'h0C
`define OFS_CUTOFF        8'h10
`define OFS_VUNIT         8'h14
`define OFS_TUNIT         8'h18
`define OFS_SIM_START     8'h1C
`define OFS_SIM_INC       8'h20
`define OFS_SIM_IVL       8'h24
`define OFS_SIM_CNT       8'h28
`define OFS_SIM_STOP      8'h2C
`define OFS_STATUS        8'h30
`define OFS_FLOW          8'h34
`define OFS_TOTAL         8'h38
`define OFS_PART          8'h3C
`define OFS_TEMP          8'h40
// control fields
`define CTRL_STD          0
`define CTRL_BIDIR_T      1
`define CTRL_BIDIR_P      2
`define CTRL_PCLR         3
`define CTRL_SIM_EN       4
`define CTRL_STYPE_LO     5
`define CTRL_STGT_LO      7
// filter fields
`define FLT_FAC_LO        0
`define FLT_THR_LO        8
`define FLT_SCONF_LO      16
`define FLT_ZCONF_LO      24
// reset values
`define RST_CTRL          9'h001
`define RST_FACTOR        8'h19
`define RST_THR           7'h0A
`define RST_CONF          5'h01
`define RST_SPAN          24'h00EA60
`define RST_RSTART        24'h0003E8
`define RST_VUNIT         32'h000003E8
`define RST_TUNIT         16'h0064
`define RST_SIM_IVL       16'h0032
`define RST_SIM_CNT       16'h000A
`define RST_SIM_STOP      5'h01
// simulation waveforms and targets
`define SIM_TRI           2'h0
`define SIM_MONO          2'h1
`define SIM_STATIC        2'h2
`define TGT_FLOW          2'h0
`define TGT_TEMP          2'h1
`define TGT_PART          2'h2

`endif

// ==== design/flow_value_conditioning.v ====
// What this block does
// - step detection in standard filter, both directions
// - step threshold is fraction of span
// - consecutive exceed count confirms step, else clear
// - confirmed step fills filter history with raw
// - zero forced after confirmed run below start
// - leaving zero needs same confirmed run
// - below cutoff flow is zero, flag raised
// - low cutoff holds zero until above start
// - absolute mode adds increment magnitude
// - bidirectional mode adds signed increment
// - unit change keeps accumulated quantity
// - user volume unit divides litre total
// - user clear resets part totalizer only
// - flow, temp, part independently simulable
// - simulation stops on timeout or intervals
// - simulation runs only outside configuration menu
// - three simulation waveform types
// - triangle ramps up then down repeatedly
// - monotonic ramps up then ends
// - user temperature unit divides register temperature, not temp_out
// - processing once per twenty millisecond tick
// - standard filter averages last factor samples
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`include "flow_cond_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module flow_value_conditioning #(
  parameter integer TICK_CYCLES = `SAMPLE_MS * `CLK_MHZ * 1000,
  parameter integer HIST        = 250,
  parameter [63:0]  OVF_LITRES  = 64'd10000000000
) (
  // clock and reset
  input  wire               clk_sys,
  input  wire               rst_n,
  // ahb-lite slave
  input  wire               hsel,
  input  wire [31:0]        haddr,
  input  wire [1:0]         htrans,
  input  wire               hwrite,
  input  wire [2:0]         hsize,
  input  wire               hready,
  input  wire [31:0]        hwdata,
  output reg  [31:0]        hrdata,
  output reg                hreadyout,
  output reg                hresp,
  // measurement stream
  input  wire signed [23:0] flow_raw,
  input  wire signed [15:0] temp_raw,
  input  wire               menu_active,
  // conditioned values
  output reg  signed [23:0] flow_out,
  output reg  signed [15:0] temp_out,
  output reg                cutoff_active
);

  localparam integer TPM = `SIM_MIN_MS / `SAMPLE_MS;

  function [31:0] div_rd;
    input signed [63:0] acc;
    input [31:0]        unit;
    reg   [63:0]        den;
    reg signed [63:0]   q;
    begin
      den = (unit == 32'h0) ? 64'h1 : {32'h0, unit};
      den = den * TPM;
      q = acc / $signed(den);
      div_rd = q[31:0];
    end
  endfunction

  function signed [63:0] tot_next;
    input signed [63:0] acc;
    input signed [23:0] inc;
    input               bidir;
    reg signed [63:0]   s;
    begin
      if (bidir || !inc[23])
        s = acc + {{40{inc[23]}}, inc};
      else
        s = acc - {{40{inc[23]}}, inc};
      if (s > $signed(OVF_LITRES * 1000 * TPM))
        tot_next = 64'sh0;
      else
        tot_next = s;
    end
  endfunction

  // sample tick
  reg [31:0] tick_cnt_q;
  reg        tick_q;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == TICK_CYCLES - 1)
    begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // registers
  reg [8:0]  ctrl_q;
  reg [7:0]  factor_q;
  reg [6:0]  thr_q;
  reg [4:0]  sconf_q;
  reg [4:0]  zconf_q;
  reg [23:0] span_q;
  reg [23:0] rstart_q;
  reg [23:0] cutoff_q;
  reg [31:0] vunit_q;
  reg [15:0] tunit_q;
  reg [31:0] sim_start_q;
  reg [31:0] sim_inc_q;
  reg [15:0] sim_ivl_q;
  reg [15:0] sim_cnt_q;
  reg [4:0]  sim_stop_q;
  reg        pclr_q;
  reg        refill_q;
  // ahb data phase
  reg        wr_q;
  reg [7:0]  wa_q;

  wire       addr_ok = hsel && hready && htrans[1];
  wire [1:0] stype   = ctrl_q[`CTRL_STYPE_LO +: 2];
  wire [1:0] stgt    = ctrl_q[`CTRL_STGT_LO +: 2];

  // state read back
  reg               step_q;
  reg               zero_q;
  reg               sim_run_q;
  reg signed [31:0] sim_val_q;
  reg [31:0]        total_rd_q;
  reg [31:0]        part_rd_q;
  reg [31:0]        temp_rd_q;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_q      <= 1'b0;
      wa_q      <= 8'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_q <= addr_ok && hwrite;
      wa_q <= haddr[7:0];
      if (addr_ok && !hwrite)
      begin
        if (haddr[7:0] == `OFS_CTRL)
          hrdata <= {23'h0, ctrl_q};
        else if (haddr[7:0] == `OFS_FILTER)
          hrdata <= {3'h0, zconf_q, 3'h0, sconf_q, 1'b0, thr_q, factor_q};
        else if (haddr[7:0] == `OFS_SPAN)
          hrdata <= {8'h0, span_q};
        else if (haddr[7:0] == `OFS_RSTART)
          hrdata <= {8'h0, rstart_q};
        else if (haddr[7:0] == `OFS_CUTOFF)
          hrdata <= {8'h0, cutoff_q};
        else if (haddr[7:0] == `OFS_VUNIT)
          hrdata <= vunit_q;
        else if (haddr[7:0] == `OFS_TUNIT)
          hrdata <= {16'h0, tunit_q};
        else if (haddr[7:0] == `OFS_SIM_START)
          hrdata <= sim_start_q;
        else if (haddr[7:0] == `OFS_SIM_INC)
          hrdata <= sim_inc_q;
        else if (haddr[7:0] == `OFS_SIM_IVL)
          hrdata <= {16'h0, sim_ivl_q};
        else if (haddr[7:0] == `OFS_SIM_CNT)
          hrdata <= {16'h0, sim_cnt_q};
        else if (haddr[7:0] == `OFS_SIM_STOP)
          hrdata <= {27'h0, sim_stop_q};
        else if (haddr[7:0] == `OFS_STATUS)
          hrdata <= {28'h0, sim_run_q, step_q, zero_q, cutoff_active};
        else if (haddr[7:0] == `OFS_FLOW)
          hrdata <= {{8{flow_out[23]}}, flow_out};
        else if (haddr[7:0] == `OFS_TOTAL)
          hrdata <= total_rd_q;
        else if (haddr[7:0] == `OFS_PART)
          hrdata <= part_rd_q;
        else if (haddr[7:0] == `OFS_TEMP)
          hrdata <= temp_rd_q;
        else
          hrdata <= 32'h0;
      end
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_q      <= `RST_CTRL;
      factor_q    <= `RST_FACTOR;
      thr_q       <= `RST_THR;
      sconf_q     <= `RST_CONF;
      zconf_q     <= `RST_CONF;
      span_q      <= `RST_SPAN;
      rstart_q    <= `RST_RSTART;
      cutoff_q    <= `RST_RSTART;
      vunit_q     <= `RST_VUNIT;
      tunit_q     <= `RST_TUNIT;
      sim_start_q <= 32'h0;
      sim_inc_q   <= 32'h1;
      sim_ivl_q   <= `RST_SIM_IVL;
      sim_cnt_q   <= `RST_SIM_CNT;
      sim_stop_q  <= `RST_SIM_STOP;
      pclr_q      <= 1'b0;
      refill_q    <= 1'b1;
    end
    else
    begin
      pclr_q <= 1'b0;
      if (tick_q)
        refill_q <= 1'b0;
      if (wr_q)
      begin
        if (wa_q == `OFS_CTRL)
        begin
          ctrl_q <= hwdata[8:0] & 9'h1F7;
          pclr_q <= hwdata[`CTRL_PCLR];
        end
        else if (wa_q == `OFS_FILTER)
        begin
          factor_q <= (hwdata[7:0] == 8'h0) ? 8'h1 : hwdata[7:0];
          thr_q    <= hwdata[`FLT_THR_LO +: 7];
          sconf_q  <= hwdata[`FLT_SCONF_LO +: 5];
          zconf_q  <= hwdata[`FLT_ZCONF_LO +: 5];
          refill_q <= 1'b1;
        end
        else if (wa_q == `OFS_SPAN)
          span_q <= hwdata[23:0];
        else if (wa_q == `OFS_RSTART)
          rstart_q <= hwdata[23:0];
        else if (wa_q == `OFS_CUTOFF)
          cutoff_q <= hwdata[23:0];
        else if (wa_q == `OFS_VUNIT)
          vunit_q <= hwdata;
        else if (wa_q == `OFS_TUNIT)
          tunit_q <= hwdata[15:0];
        else if (wa_q == `OFS_SIM_START)
          sim_start_q <= hwdata;
        else if (wa_q == `OFS_SIM_INC)
          sim_inc_q <= hwdata;
        else if (wa_q == `OFS_SIM_IVL)
          sim_ivl_q <= hwdata[15:0];
        else if (wa_q == `OFS_SIM_CNT)
          sim_cnt_q <= hwdata[15:0];
        else if (wa_q == `OFS_SIM_STOP)
          sim_stop_q <= hwdata[4:0];
      end
    end
  end

  // rolling average with step bypass
  reg signed [23:0] hist_q [0:HIST-1];
  reg signed [31:0] sum_q;
  reg signed [23:0] avg_q;
  reg [7:0]         ptr_q;
  reg [4:0]         scnt_q;
  reg [4:0]         zcnt_q;
  integer           i;

  wire signed [24:0] dev     = {flow_raw[23], flow_raw} - {avg_q[23], avg_q};
  wire [24:0]        dev_abs = dev[24] ? -dev : dev;
  wire [31:0]        thr_abs = ({8'h0, span_q} * {25'h0, thr_q}) / 32'd100;
  wire               exceed  = {7'h0, dev_abs} > thr_abs;
  wire               fire    = ctrl_q[`CTRL_STD] && exceed &&
                               (scnt_q + 5'h1 >= sconf_q);
  wire [23:0]        raw_abs = flow_raw[23] ? -flow_raw : flow_raw;
  wire               below   = raw_abs < rstart_q;
  wire signed [31:0] sum_nx  = sum_q + {{8{flow_raw[23]}}, flow_raw}
                               - {{8{hist_q[ptr_q][23]}}, hist_q[ptr_q]};
  wire signed [31:0] avg_nx  = sum_nx / $signed({24'h0, factor_q});

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sum_q  <= 32'sh0;
      avg_q  <= 24'sh0;
      ptr_q  <= 8'h0;
      scnt_q <= 5'h0;
      zcnt_q <= 5'h0;
      step_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (tick_q)
    begin
      if (fire || refill_q)
      begin
        for (i = 0; i < HIST; i = i + 1)
          hist_q[i] <= flow_raw;
        sum_q  <= {{8{flow_raw[23]}}, flow_raw} * $signed({24'h0, factor_q});
        avg_q  <= flow_raw;
        ptr_q  <= 8'h0;
        scnt_q <= 5'h0;
        step_q <= fire;
      end
      else
      begin
        hist_q[ptr_q] <= flow_raw;
        sum_q  <= sum_nx;
        avg_q  <= avg_nx[23:0];
        ptr_q  <= (ptr_q + 8'h1 >= factor_q) ? 8'h0 : ptr_q + 8'h1;
        scnt_q <= (exceed && ctrl_q[`CTRL_STD]) ? scnt_q + 5'h1 : 5'h0;
        step_q <= 1'b0;
      end
      if (below != zero_q)
      begin
        if (zcnt_q + 5'h1 >= zconf_q)
        begin
          zero_q <= below;
          zcnt_q <= 5'h0;
        end
        else
          zcnt_q <= zcnt_q + 5'h1;
      end
      else
        zcnt_q <= 5'h0;
    end
  end

  // simulation generator
  reg [15:0] ivl_cnt_q;
  reg [15:0] n_q;
  reg        down_q;
  reg [15:0] min_tick_q;
  reg [4:0]  min_q;
  reg        done_q;

  wire signed [31:0] sim_step = down_q ? -sim_inc_q : sim_inc_q;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sim_run_q  <= 1'b0;
      sim_val_q  <= 32'sh0;
      ivl_cnt_q  <= 16'h0;
      n_q        <= 16'h0;
      down_q     <= 1'b0;
      min_tick_q <= 16'h0;
      min_q      <= 5'h0;
      done_q     <= 1'b0;
    end
    else if (menu_active || !ctrl_q[`CTRL_SIM_EN])
    begin
      sim_run_q <= 1'b0;
      done_q    <= 1'b0;
    end
    else if (!sim_run_q && !done_q)
    begin
      sim_run_q  <= 1'b1;
      sim_val_q  <= (stype == `SIM_STATIC && stgt == `TGT_PART) ?
                    sim_start_q + sim_inc_q : sim_start_q;
      ivl_cnt_q  <= 16'h0;
      n_q        <= 16'h0;
      down_q     <= 1'b0;
      min_tick_q <= 16'h0;
      min_q      <= 5'h0;
    end
    else if (sim_run_q && tick_q)
    begin
      if (min_tick_q == TPM - 1)
      begin
        min_tick_q <= 16'h0;
        min_q      <= min_q + 5'h1;
        if (min_q + 5'h1 >= sim_stop_q)
        begin
          sim_run_q <= 1'b0;
          done_q    <= 1'b1;
        end
      end
      else
        min_tick_q <= min_tick_q + 16'h1;
      if (ivl_cnt_q + 16'h1 >= sim_ivl_q)
      begin
        ivl_cnt_q <= 16'h0;
        case (stype)
          `SIM_TRI:
          begin
            sim_val_q <= sim_val_q + sim_step;
            if (n_q + 16'h1 >= sim_cnt_q)
            begin
              n_q    <= 16'h0;
              down_q <= !down_q;
            end
            else
              n_q <= n_q + 16'h1;
          end
          `SIM_MONO:
          begin
            sim_val_q <= sim_val_q + sim_inc_q;
            n_q       <= n_q + 16'h1;
            if (n_q + 16'h1 >= sim_cnt_q)
            begin
              sim_run_q <= 1'b0;
              done_q    <= 1'b1;
            end
          end
          default:
            sim_val_q <= sim_val_q;
        endcase
      end
      else
        ivl_cnt_q <= ivl_cnt_q + 16'h1;
    end
  end

  // output stage and totalizers
  reg signed [63:0] total_q;
  reg signed [63:0] part_q;

  wire signed [23:0] filt   = zero_q ? 24'sh0 : avg_q;
  wire [23:0]        f_abs  = filt[23] ? -filt : filt;
  wire               hold   = (cutoff_q < rstart_q) && (raw_abs <= rstart_q);
  wire               cut    = (f_abs < cutoff_q) || hold;
  wire               sim_f  = sim_run_q && stgt == `TGT_FLOW;
  wire               sim_t  = sim_run_q && stgt == `TGT_TEMP;
  wire               sim_p  = sim_run_q && stgt == `TGT_PART;
  wire signed [15:0] t_cur  = sim_t ? sim_val_q[15:0] : temp_raw;
  wire signed [15:0] t_unit = (tunit_q == 16'h0) ? 16'sh1 : $signed(tunit_q);
  wire signed [15:0] t_div  = t_cur / t_unit;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      flow_out      <= 24'sh0;
      temp_out      <= 16'sh0;
      cutoff_active <= 1'b0;
      total_q       <= 64'sh0;
      part_q        <= 64'sh0;
      total_rd_q    <= 32'h0;
      part_rd_q     <= 32'h0;
      temp_rd_q     <= 32'h0;
    end
    else
    begin
      if (tick_q)
      begin
        flow_out      <= sim_f ? sim_val_q[23:0] : (cut ? 24'sh0 : filt);
        cutoff_active <= cut && !sim_f;
        temp_out      <= t_cur;
        temp_rd_q     <= {{16{t_div[15]}}, t_div};
        total_q       <= tot_next(total_q, flow_out, ctrl_q[`CTRL_BIDIR_T]);
        if (!pclr_q)
          part_q <= tot_next(part_q, flow_out, ctrl_q[`CTRL_BIDIR_P]);
      end
      if (pclr_q)
        part_q <= 64'sh0;
      total_rd_q <= div_rd(total_q, vunit_q);
      part_rd_q  <= sim_p ? sim_val_q : div_rd(part_q, vunit_q);
    end
  end

endmodule // flow_value_conditioning

`default_nettype wire

// ==== dv/flow_cond_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module flow_cond_monitor #(
  parameter integer TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // bus
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // conditioned values
  input wire logic signed [23:0] flow_out,
  input wire logic signed [15:0] temp_out,
  input wire logic               cutoff_active
);
  logic [31:0] gap_q;
  logic        rd_q;

  // cycles since any conditioned output last moved
  always @(posedge clk_sys)
  begin
    if (!rst_n || $changed(flow_out) || $changed(temp_out) || $changed(cutoff_active))
      gap_q <= 32'h0;
    else
      gap_q <= gap_q + 32'h1;
    rd_q <= rst_n && hsel && htrans[1] && !hwrite && hready;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_RESP_OKAY: assert property (hsel && htrans[1] && hready |=> hreadyout && !hresp)
    else $error("bus answer not ready okay");
  AST_RESET_OUT: assert property (disable iff (1'b0) !rst_n |=> flow_out == 24'sh0
    && temp_out == 16'sh0 && !cutoff_active) else $error("outputs not cleared by reset");
  AST_RESET_RDATA: assert property (disable iff (1'b0) !rst_n |=> hrdata == 32'h0)
    else $error("read data not cleared by reset");
  AST_CUTOFF_ZERO: assert property (cutoff_active |-> flow_out == 24'sh0)
    else $error("flow not zero under cutoff");
  AST_FLOW_TICK: assert property ($changed(flow_out) |-> gap_q >= TICK_CYCLES - 1)
    else $error("flow moved off the sample tick");
  AST_TEMP_TICK: assert property ($changed(temp_out) |-> gap_q >= TICK_CYCLES - 1)
    else $error("temperature moved off the sample tick");
  AST_CUT_TICK: assert property ($changed(cutoff_active) |-> gap_q >= TICK_CYCLES - 1)
    else $error("cutoff flag moved off the sample tick");
  AST_RDATA_HOLD: assert property ($changed(hrdata) |-> rd_q)
    else $error("read data moved without a read");

  cover property ($rose(cutoff_active));
  cover property ($fell(cutoff_active));
  cover property (rd_q && hrdata != 32'h0);
endmodule // flow_cond_monitor

bind flow_value_conditioning flow_cond_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_flow_cond_monitor (
  .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .flow_out(flow_out), .temp_out(temp_out), .cutoff_active(cutoff_active));
`default_nettype wire

// ==== dv/flow_sensor_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module flow_sensor_model (
  // clock
  input  wire logic               clk_sys,
  // requested values
  input  wire logic signed [23:0] flow_set,
  input  wire logic signed [15:0] temp_set,
  // sample stream
  output var logic signed [23:0]  flow_raw = 24'sh0,
  output var logic signed [15:0]  temp_raw = 16'sh0
);
  // values move only just after an edge
  always @(posedge clk_sys)
  begin
    flow_raw <= flow_set;
    temp_raw <= temp_set;
  end
endmodule // flow_sensor_model
`default_nettype wire

// ==== dv/flow_value_conditioning_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "flow_cond_consts.vh"
module flow_value_conditioning_tb;
  localparam integer TK = 20;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h0;
  logic               menu_active = 1'b0;
  logic signed [23:0] fset = 24'sh0;
  logic signed [15:0] tset = 16'sh09C4;
  logic signed [31:0] r, p, q;
  wire [31:0]         hrdata;
  wire                hreadyout, hresp, cutoff_active;
  wire signed [23:0]  flow_raw, flow_out;
  wire signed [15:0]  temp_raw, temp_out;
  int                 miscompares = 0;
  int                 comparisons = 0;

  always #2.5 clk_sys = ~clk_sys;

  flow_sensor_model i_flow_sensor_model (.clk_sys(clk_sys), .flow_set(fset), .temp_set(tset),
    .flow_raw(flow_raw), .temp_raw(temp_raw));
  flow_value_conditioning #(.TICK_CYCLES(TK), .HIST(250), .OVF_LITRES(64'd2))
  i_flow_value_conditioning (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flow_raw(flow_raw),
    .temp_raw(temp_raw), .menu_active(menu_active), .flow_out(flow_out),
    .temp_out(temp_out), .cutoff_active(cutoff_active));

  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic signed [31:0] got, lo, hi, input string m);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      miscompares++;
      $display("mismatch at %0t: %s, got %0d", $time, m, got);
    end
  endtask

  task automatic wrdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 9);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rv);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic signed [31:0] v);
    bus(a, 1'b0, 32'h0, v);
  endtask

  task automatic tk(input int n);
    repeat (n * TK) @(posedge clk_sys);
  endtask

  task automatic t_regs;
    logic [7:0]  a[9] = '{`OFS_CTRL, `OFS_FILTER, `OFS_SPAN, `OFS_RSTART, `OFS_CUTOFF,
                          `OFS_VUNIT, `OFS_TUNIT, `OFS_SIM_IVL, `OFS_SIM_CNT};
    logic [31:0] e[9] = '{32'h1, 32'h01010A19, 32'hEA60, 32'h3E8, 32'h3E8, 32'h3E8, 32'h64,
                          32'h32, 32'hA};
    for (int i = 0; i < 9; i++)
    begin
      rd(a[i], r);
      chk(r, e[i], e[i], "reset value");
    end
    wr(8'h44, 32'h5A5A5A5A);
    rd(8'h44, r);
    chk(r, 0, 0, "unmapped read");
    tk(3);
    rd(`OFS_TEMP, r);
    chk(r, 25, 25, "temperature unit");
    wr(`OFS_TUNIT, 32'd50);
    tk(2);
    rd(`OFS_TEMP, r);
    chk(r, 50, 50, "user temperature unit");
    $display("t_regs done");
  endtask

  task automatic t_step;
    fset <= 24'sd10000;
    wr(`OFS_FILTER, 32'h01030AC8);
    tk(3);
    chk(flow_out, 10000, 10000, "steady average");
    fset <= 24'sd30000;
    tk(2);
    chk(flow_out, 10000, 29999, "step before confirm");
    tk(4);
    chk(flow_out, 30000, 30000, "rising step");
    fset <= 24'sd10000;
    tk(6);
    chk(flow_out, 10000, 10000, "falling step");
    fset <= 24'sd15000;
    tk(6);
    chk(flow_out, 10000, 14999, "inside threshold");
    repeat (3)
    begin
      fset <= 24'sd30000;
      tk(2);
      fset <= 24'sd10000;
      tk(1);
    end
    chk(flow_out, 10000, 20000, "interrupted run");
    wr(`OFS_CTRL, 32'h0);
    fset <= 24'sd30000;
    tk(6);
    chk(flow_out, 10000, 29999, "no step off standard");
    wr(`OFS_CTRL, 32'h1);
    $display("t_step done");
  endtask

  task automatic t_zero;
    wr(`OFS_FILTER, 32'h04010A01);
    fset <= 24'sd500;
    tk(2);
    rd(`OFS_STATUS, r);
    chk(r[1], 0, 0, "zero before confirm");
    chk(flow_out, 0, 0, "cutoff zero");
    chk(cutoff_active, 1, 1, "cutoff flag");
    tk(5);
    rd(`OFS_STATUS, r);
    chk(r[1], 1, 1, "zero forced");
    fset <= 24'sd5000;
    tk(2);
    rd(`OFS_STATUS, r);
    chk(r[1], 1, 1, "zero held");
    tk(5);
    rd(`OFS_STATUS, r);
    chk(r[1], 0, 0, "zero released");
    chk(flow_out, 5000, 5000, "flow back");
    chk(cutoff_active, 0, 0, "cutoff flag off");
    wr(`OFS_CUTOFF, 32'd200);
    fset <= 24'sd800;
    tk(3);
    chk(flow_out, 0, 0, "held below start");
    fset <= 24'sd1500;
    tk(7);
    chk(flow_out, 1500, 1500, "above start");
    $display("t_zero done");
  endtask

  task automatic t_total;
    wr(`OFS_VUNIT, 32'd1);
    fset <= 24'sd30000;
    wr(`OFS_CTRL, 32'h9);
    tk(30);
    rd(`OFS_PART, p);
    chk(p, 270, 310, "part volume");
    wr(`OFS_VUNIT, 32'd10);
    rd(`OFS_PART, q);
    chk(q, p / 10, p / 10 + 2, "unit change");
    fset <= -24'sd30000;
    tk(20);
    rd(`OFS_PART, r);
    chk(r, q + 16, q + 24, "absolute count");
    wr(`OFS_CTRL, 32'hD);
    tk(20);
    rd(`OFS_PART, r);
    chk(r, -24, -16, "below zero");
    rd(`OFS_TOTAL, p);
    wr(`OFS_CTRL, 32'hD);
    rd(`OFS_TOTAL, q);
    chk(q, p, p + 2, "total kept");
    rd(`OFS_PART, r);
    chk(r, -2, 0, "part cleared");
    fset <= 24'sd30000;
    wr(`OFS_CTRL, 32'h9);
    tk(210);
    rd(`OFS_PART, r);
    chk(r, 0, 30, "part wraps");
    $display("t_total done");
  endtask

  task automatic t_sim;
    fset <= 24'sd2000;
    menu_active <= 1'b1;
    wr(`OFS_FILTER, 32'h01010A01);
    wr(`OFS_SIM_START, 32'd5000);
    wr(`OFS_SIM_INC, 32'd1000);
    wr(`OFS_SIM_IVL, 32'd2);
    wr(`OFS_SIM_CNT, 32'd3);
    wr(`OFS_CTRL, 32'h31);
    tk(3);
    rd(`OFS_STATUS, r);
    chk(r[3], 0, 0, "sim held by menu");
    chk(flow_out, 2000, 2000, "real flow");
    menu_active <= 1'b0;
    p = 0;
    repeat (12)
    begin
      tk(1);
      if (flow_out > p)
        p = flow_out;
    end
    chk(p, 7000, 8000, "monotonic peak");
    rd(`OFS_STATUS, r);
    chk(r[3], 0, 0, "sim ended");
    chk(flow_out, 2000, 2000, "flow after sim");
    menu_active <= 1'b1;
    wr(`OFS_SIM_START, 32'd100);
    wr(`OFS_SIM_INC, 32'd10);
    wr(`OFS_SIM_IVL, 32'd1);
    wr(`OFS_SIM_CNT, 32'd2);
    wr(`OFS_CTRL, 32'h91);
    menu_active <= 1'b0;
    tk(2);
    p = 999;
    q = -999;
    repeat (10)
    begin
      tk(1);
      if (temp_out < p)
        p = temp_out;
      if (temp_out > q)
        q = temp_out;
      chk(flow_out, 2000, 2000, "flow untouched");
    end
    chk(p, 100, 100, "triangle low");
    chk(q, 120, 120, "triangle high");
    rd(`OFS_STATUS, r);
    chk(r[3], 1, 1, "sim running");
    menu_active <= 1'b1;
    tk(2);
    rd(`OFS_STATUS, r);
    chk(r[3], 0, 0, "menu stops sim");
    wr(`OFS_SIM_START, 32'd5000);
    wr(`OFS_CTRL, 32'h51);
    menu_active <= 1'b0;
    tk(3);
    chk(flow_out, 5000, 5000, "static flow");
    $display("t_sim done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_step();
    t_zero();
    t_total();
    t_sim();
    stop_test();
  end
endmodule // flow_value_conditioning_tb
`default_nettype wire
